// [common/serial_consts.svh]
/*
 Constants for the dual four-mode serial port: register offsets, field
 positions, reset values and bit timing. Assumes a Wishbone byte address.
*/
// Summary of operation
// - two identical ports, each with its own control and buffer register.
// - in modes 1 to 3, transmit and receive paths of a port run independently and together.
// - receiver may shift a new byte while the previous one waits unread.
// - a byte finishing while the earlier is unread is lost.
// - buffer write loads transmitter; buffer read returns separate receive register.
// - mode 0 shifts 8 bits LSB first on rx line, clock on tx, fosc/12.
// - mode 1 frame is start 0, 8 data LSB first, stop 1.
// - mode 1 receive stores the stop bit in the received ninth bit.
// - mode 2 frame has 11 bits; ninth sent bit comes from control.
// - mode 2 receive stores ninth bit and ignores the stop bit.
// - mode 2 bit rate is fosc/32 or fosc/64.
// - mode 3 equals mode 2 but uses the variable bit rate.
// - any buffer write starts a transmission in every mode; the code starts one only when byte lane 0 (sel_i[0]) is selected.
// - mode 0 reception starts when receive flag is 0 and receiver enabled; the code also waits for an idle transmitter.
// - modes 1 to 3 start reception on a start bit when enabled.
// - modes 2 and 3 offer a multiprocessor option gated by ninth bit.
// - variable rate of modes 1 and 3 comes from a reload timer overflow.
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH
`define CTRL0_OFS     3'h0
`define BUF0_OFS      3'h1
`define CTRL1_OFS     3'h2
`define BUF1_OFS      3'h3
`define RELOAD_OFS    3'h4
`define CTRL_RST      9'h000
`define RELOAD_RST    8'h00
`define F_RXDONE      0
`define F_TXDONE      1
`define F_RXNINTH     2
`define F_TXNINTH     3
`define F_RXEN        4
`define F_MP          5
`define F_MODE_LO     6
`define F_RATEHI      8
`define M0_LAST       4'hB
`define M0_HALF       4'h6
`define OVS_LAST      4'hF
`define OVS_MID       4'h7
`define M0_BITS       4'h8
`define M1_BITS       4'hA
`define M2_BITS       4'hB
`endif

// [common/serial_pkg.sv]
/*
 Types for the dual serial port. Assumes serial_consts.svh for the numbers.
*/
package serial_pkg;
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'h0,
		MODE_ASYNC8 = 2'h1,
		MODE_FIX9 = 2'h2,
		MODE_VAR9 = 2'h3
	} mode_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_START = 2'h1,
		ST_SHIFT = 2'h3
	} xfer_e;
	typedef struct packed {
		logic  rateHi;
		mode_e mode;
		logic  mp;
		logic  rxEn;
		logic  txNinth;
		logic  rxNinth;
		logic  txDone;
		logic  rxDone;
	} serial_ctrl_s;
endpackage

// [rtl/dual_serial_port.sv]
/*
 Two four-mode serial ports behind a classic Wishbone slave, sharing one
 reload timer as bit-rate generator. Assumes ref_clk is the oscillator clock
 and that rx pins are asynchronous to it.
*/
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "serial_consts.svh"
module dual_serial_port
	import serial_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic [1:0]  rxdIn,
	output logic      [1:0]  rxdOut,
	output logic      [1:0]  rxdOe,
	output logic      [1:0]  txdOut
);
	serial_ctrl_s ctrl_ff [2];
	serial_ctrl_s nxt_ctrl [2];
	logic [7:0]   rxBuf_ff [2];
	logic [7:0]   nxt_rxBuf [2];
	xfer_e        txSt_ff [2];
	xfer_e        nxt_txSt [2];
	xfer_e        rxSt_ff [2];
	xfer_e        nxt_rxSt [2];
	logic [10:0]  txSh_ff [2];
	logic [10:0]  nxt_txSh [2];
	logic [9:0]   rxSh_ff [2];
	logic [9:0]   nxt_rxSh [2];
	logic [3:0]   txCnt_ff [2];
	logic [3:0]   nxt_txCnt [2];
	logic [3:0]   rxCnt_ff [2];
	logic [3:0]   nxt_rxCnt [2];
	logic [3:0]   txTick_ff [2];
	logic [3:0]   nxt_txTick [2];
	logic [3:0]   rxTick_ff [2];
	logic [3:0]   nxt_rxTick [2];
	logic [1:0]   presc_ff [2];
	logic [1:0]   nxt_presc [2];
	logic [1:0]   rxMeta_ff;
	logic [1:0]   rxSync_ff;
	logic [1:0]   rxLast_ff;
	logic [1:0]   nxt_rxdOut;
	logic [1:0]   nxt_rxdOe;
	logic [1:0]   nxt_txdOut;
	logic [7:0]   tmr_ff;
	logic [7:0]   nxt_tmr;
	logic [7:0]   reload_ff;
	logic [7:0]   nxt_reload;
	logic [31:0]  nxt_dat;
	logic         nxt_ack;

	function automatic logic hit(input logic [7:0] adr, input logic [2:0] ofs);
		hit = (adr[7:5] == 3'h0) && (adr[4:2] == ofs);
	endfunction

	// offset of one port's control or buffer register
	function automatic logic [2:0] port_ofs(input logic p, input logic isBuf);
		if (p)
			port_ofs = isBuf ? `BUF1_OFS : `CTRL1_OFS;
		else
			port_ofs = isBuf ? `BUF0_OFS : `CTRL0_OFS;
	endfunction

	// advance a bit-time counter; mode 0 wraps at twelve clocks
	function automatic logic [3:0] step(input logic [3:0] t, input logic m0);
		step = (m0 && t == `M0_LAST) ? 4'h0 : t + 4'h1;
	endfunction

	always_comb begin
		logic         req;
		logic         wr;
		logic         ovf;
		logic         m0;
		logic         nine;
		logic         tick;
		logic         bitEnd;
		logic [9:0]   s;
		logic         ninth;
		logic         take;
		serial_ctrl_s c;
		req = cyc_i && stb_i && !ack_o;
		wr = req && we_i;
		ovf = (tmr_ff == 8'hFF);
		m0 = 1'b0;
		nine = 1'b0;
		tick = 1'b0;
		bitEnd = 1'b0;
		s = 10'h000;
		ninth = 1'b0;
		take = 1'b0;
		c = ctrl_ff[0];
		nxt_ack = req;
		// a new reload value takes hold at the next overflow only
		nxt_tmr = ovf ? reload_ff : tmr_ff + 8'h01;
		nxt_reload = reload_ff;
		if (wr && sel_i[0] && hit(adr_i, `RELOAD_OFS)) begin
			nxt_reload = dat_i[7:0];
		end
		nxt_dat = dat_o;
		if (req) begin
			nxt_dat = 32'h0000_0000;
			if (hit(adr_i, `CTRL0_OFS))
				nxt_dat[8:0] = ctrl_ff[0];
			if (hit(adr_i, `CTRL1_OFS))
				nxt_dat[8:0] = ctrl_ff[1];
			if (hit(adr_i, `BUF0_OFS))
				nxt_dat[7:0] = rxBuf_ff[0];
			if (hit(adr_i, `BUF1_OFS))
				nxt_dat[7:0] = rxBuf_ff[1];
			if (hit(adr_i, `RELOAD_OFS))
				nxt_dat[7:0] = reload_ff;
		end
		for (int p = 0; p < 2; p++) begin
			c = ctrl_ff[p];
			nxt_rxBuf[p] = rxBuf_ff[p];
			nxt_txSt[p] = txSt_ff[p];
			nxt_rxSt[p] = rxSt_ff[p];
			nxt_txSh[p] = txSh_ff[p];
			nxt_rxSh[p] = rxSh_ff[p];
			nxt_txCnt[p] = txCnt_ff[p];
			nxt_rxCnt[p] = rxCnt_ff[p];
			nxt_txTick[p] = txTick_ff[p];
			nxt_rxTick[p] = rxTick_ff[p];
			nxt_presc[p] = presc_ff[p] + 2'h1;
			// software writes first, so hardware sets below win the cycle
			if (wr && hit(adr_i, port_ofs(p[0], 1'b0))) begin
				if (sel_i[0]) begin
					c.mode = mode_e'(dat_i[`F_MODE_LO+1:`F_MODE_LO]);
					c.mp = dat_i[`F_MP];
					c.rxEn = dat_i[`F_RXEN];
					c.txNinth = dat_i[`F_TXNINTH];
					c.rxNinth = dat_i[`F_RXNINTH];
					c.txDone = dat_i[`F_TXDONE];
					c.rxDone = dat_i[`F_RXDONE];
				end
				if (sel_i[1])
					c.rateHi = dat_i[`F_RATEHI];
			end
			m0 = (ctrl_ff[p].mode == MODE_SHIFT);
			nine = ctrl_ff[p].mode[1];
			case (ctrl_ff[p].mode)
				MODE_SHIFT: tick = 1'b1;
				MODE_FIX9: begin
					// sixteen ticks a bit: fosc/32 with rateHi, else fosc/64
					tick = ctrl_ff[p].rateHi ? presc_ff[p][0] : (presc_ff[p] == 2'h3);
				end
				default: tick = ovf;
			endcase
			// transmit path
			if (txSt_ff[p] == ST_SHIFT && tick) begin
				nxt_txTick[p] = step(txTick_ff[p], m0);
				bitEnd = m0 ? (txTick_ff[p] == `M0_LAST) : (txTick_ff[p] == `OVS_LAST);
				if (bitEnd) begin
					nxt_txSh[p] = {1'b1, txSh_ff[p][10:1]};
					nxt_txCnt[p] = txCnt_ff[p] - 4'h1;
					if (txCnt_ff[p] == 4'h1) begin
						nxt_txSt[p] = ST_IDLE;
						c.txDone = 1'b1;
					end
				end
			end
			if (wr && sel_i[0] && hit(adr_i, port_ofs(p[0], 1'b1))) begin
				nxt_txSt[p] = ST_SHIFT;
				nxt_txTick[p] = 4'h0;
				if (m0) begin
					nxt_txSh[p] = {3'h7, dat_i[7:0]};
					nxt_txCnt[p] = `M0_BITS;
				end else begin
					nxt_txSh[p] = {1'b1, nine ? ctrl_ff[p].txNinth : 1'b1, dat_i[7:0], 1'b0};
					nxt_txCnt[p] = nine ? `M2_BITS : `M1_BITS;
				end
			end
			// receive path, independent of the transmitter except for the mode 0 start
			case (rxSt_ff[p])
				ST_IDLE: begin
					nxt_rxTick[p] = 4'h0;
					if (ctrl_ff[p].rxEn) begin
						if (m0) begin
							// mode 0 shares the rx pin, so reception waits for an idle transmitter
							if (!ctrl_ff[p].rxDone && txSt_ff[p] == ST_IDLE) begin
								nxt_rxSt[p] = ST_SHIFT;
								nxt_rxCnt[p] = `M0_BITS;
							end
						end else if (rxLast_ff[p] && !rxSync_ff[p]) begin
							nxt_rxSt[p] = ST_START;
						end
					end
				end
				ST_START: begin
					if (tick) begin
						nxt_rxTick[p] = rxTick_ff[p] + 4'h1;
						if (rxTick_ff[p] == `OVS_MID) begin
							nxt_rxSt[p] = rxSync_ff[p] ? ST_IDLE : ST_SHIFT;
							nxt_rxCnt[p] = nine ? 4'hA : 4'h9;
						end
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						nxt_rxTick[p] = step(rxTick_ff[p], m0);
						if (rxTick_ff[p] == (m0 ? `M0_HALF : `OVS_MID)) begin
							s = {rxSync_ff[p], rxSh_ff[p][9:1]};
							nxt_rxSh[p] = s;
							nxt_rxCnt[p] = rxCnt_ff[p] - 4'h1;
							if (rxCnt_ff[p] == 4'h1) begin
								nxt_rxSt[p] = ST_IDLE;
								ninth = nine ? s[8] : s[9];
								// an unread byte blocks the new one, which is dropped
								take = !ctrl_ff[p].rxDone;
								if (nine && ctrl_ff[p].mp)
									take = take && ninth;
								if (take) begin
									nxt_rxBuf[p] = m0 ? s[9:2] : (nine ? s[7:0] : s[8:1]);
									if (!m0)
										c.rxNinth = ninth;
									c.rxDone = 1'b1;
								end
							end
						end
					end
				end
				default: nxt_rxSt[p] = ST_IDLE;
			endcase
			if (!ctrl_ff[p].rxEn && rxSt_ff[p] != ST_IDLE)
				nxt_rxSt[p] = ST_IDLE;
			nxt_ctrl[p] = c;
			// pins: mode 0 drives data on rx line and clock on tx line
			if (m0) begin
				nxt_rxdOut[p] = nxt_txSt[p] == ST_SHIFT ? nxt_txSh[p][0] : 1'b1;
				nxt_rxdOe[p] = (nxt_txSt[p] == ST_SHIFT);
				if (nxt_txSt[p] == ST_SHIFT)
					nxt_txdOut[p] = (nxt_txTick[p] >= `M0_HALF);
				else if (nxt_rxSt[p] == ST_SHIFT)
					nxt_txdOut[p] = (nxt_rxTick[p] >= `M0_HALF);
				else
					nxt_txdOut[p] = 1'b1;
			end else begin
				nxt_rxdOut[p] = 1'b1;
				nxt_rxdOe[p] = 1'b0;
				nxt_txdOut[p] = nxt_txSt[p] == ST_SHIFT ? nxt_txSh[p][0] : 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		rxMeta_ff <= rxdIn;
		rxSync_ff <= rxMeta_ff;
		rxLast_ff <= rxSync_ff;
		if (!rst_b) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			tmr_ff <= 8'h00;
			reload_ff <= `RELOAD_RST;
			rxdOut <= 2'h3;
			rxdOe <= 2'h0;
			txdOut <= 2'h3;
			for (int p = 0; p < 2; p++) begin
				ctrl_ff[p] <= `CTRL_RST;
				rxBuf_ff[p] <= 8'h00;
				txSt_ff[p] <= ST_IDLE;
				rxSt_ff[p] <= ST_IDLE;
				txSh_ff[p] <= 11'h7FF;
				rxSh_ff[p] <= 10'h000;
				txCnt_ff[p] <= 4'h0;
				rxCnt_ff[p] <= 4'h0;
				txTick_ff[p] <= 4'h0;
				rxTick_ff[p] <= 4'h0;
				presc_ff[p] <= 2'h0;
			end
		end else begin
			ack_o <= nxt_ack;
			dat_o <= nxt_dat;
			tmr_ff <= nxt_tmr;
			reload_ff <= nxt_reload;
			rxdOut <= nxt_rxdOut;
			rxdOe <= nxt_rxdOe;
			txdOut <= nxt_txdOut;
			for (int p = 0; p < 2; p++) begin
				ctrl_ff[p] <= nxt_ctrl[p];
				rxBuf_ff[p] <= nxt_rxBuf[p];
				txSt_ff[p] <= nxt_txSt[p];
				rxSt_ff[p] <= nxt_rxSt[p];
				txSh_ff[p] <= nxt_txSh[p];
				rxSh_ff[p] <= nxt_rxSh[p];
				txCnt_ff[p] <= nxt_txCnt[p];
				rxCnt_ff[p] <= nxt_rxCnt[p];
				txTick_ff[p] <= nxt_txTick[p];
				rxTick_ff[p] <= nxt_rxTick[p];
				presc_ff[p] <= nxt_presc[p];
			end
		end
	end
endmodule
`default_nettype wire

// [sim/dual_serial_port_asserts.sv]
/*
 Port-level checks for dual_serial_port: bus answer timing, reset levels,
 shift clock and start bit shapes. Assumes one clock, reset rst_b.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_serial_port_asserts (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [1:0]  rxdIn,
	input wire logic [1:0]  rxdOut,
	input wire logic [1:0]  rxdOe,
	input wire logic [1:0]  txdOut
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire logic req = cyc_i && stb_i && !ack_o;
	sequence seqM0Clk;
		(!txdOut[0])[*6] ##1 txdOut[0][*6];
	endsequence
	sequence seqLow(s);
		(!s)[*7];
	endsequence
	AST_ACK_NEXT:
	assert property (req |=> ack_o) else $error("ack missing after request");
	AST_ACK_ONE:
	assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	AST_ACK_CAUSE:
	assert property (ack_o |-> $past(req)) else $error("ack without request");
	AST_RST_OUT:
	assert property ($rose(rst_b) |-> txdOut == 2'h3 && rxdOut == 2'h3 && rxdOe == 2'h0
		&& !ack_o && dat_o == 32'h0) else $error("outputs not at reset level");
	AST_M0_CLK0:
	assert property ($fell(txdOut[0]) && rxdOe[0] |-> seqM0Clk) else $error("shift clock shape");
	AST_START0:
	assert property ($fell(txdOut[0]) && !rxdOe[0] ##1 !rxdOe[0] |-> seqLow(txdOut[0]))
		else $error("port 0 start bit short");
	AST_START1:
	assert property ($fell(txdOut[1]) && !rxdOe[1] ##1 !rxdOe[1] |-> seqLow(txdOut[1]))
		else $error("port 1 start bit short");
	AST_DAT_HOLD:
	assert property (!req |=> $stable(dat_o)) else $error("read data moved without request");
	AST_UNMAPPED:
	assert property (ack_o && $past(!we_i && adr_i[7:2] > 6'h4) |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind dual_serial_port dual_serial_port_asserts u_dual_serial_port_asserts (
	.ref_clk(ref_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut)
);
`default_nettype wire

// [sim/serial_partner.sv]
/*
 Remote asynchronous transmitter on a receive line. Assumes frame holds
 the bits in wire order, bit 0 first, each bitClks clocks long.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_partner (
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic [10:0] frame,
	input  wire logic [3:0]  nBits,
	input  wire logic [7:0]  bitClks,
	output logic             line,
	output logic             busy
);
	initial begin
		line = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (go) begin
				busy <= 1'b1;
				for (int i = 0; i < nBits; i++) begin
					line <= frame[i];
					repeat (bitClks) @(posedge ref_clk);
				end
				line <= 1'b1; // idle line rests at mark
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [sim/testbench.sv]
/*
 Self-checking bench for dual_serial_port over Wishbone. Assumes
 serial_partner feeds port 1 rx; port 0 rx is pulled up.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        ref_clk, rst_b, cyc, stb, we, go;
	logic [7:0]  adr, bitClks;
	logic [3:0]  sel, nBits;
	logic [31:0] dat, q;
	logic [10:0] frame;
	wire logic [31:0] datO;
	wire logic        ack, pLine, pBusy;
	wire logic [1:0]  rxO, oe, txd, rxIn;
	int mismatches, checked, cycles;
	assign rxIn[0] = oe[0] ? rxO[0] : 1'b1;
	assign rxIn[1] = oe[1] ? rxO[1] : pLine;
	dual_serial_port u_dual_serial_port (.ref_clk(ref_clk), .rst_b(rst_b), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datO),
		.ack_o(ack), .rxdIn(rxIn), .rxdOut(rxO), .rxdOe(oe), .txdOut(txd));
	serial_partner u_serial_partner (.ref_clk(ref_clk), .go(go), .frame(frame),
		.nBits(nBits), .bitClks(bitClks), .line(pLine), .busy(pBusy));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task tally_and_finish;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do @(posedge ref_clk); while (ack !== 1'b1);
		q = datO;
		{cyc, stb} <= 2'b00;
		@(posedge ref_clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task send(input logic [10:0] f, input logic [3:0] n, input logic [7:0] b);
		@(posedge ref_clk);
		{go, frame, nBits, bitClks} <= {1'b1, f, n, b};
		do @(posedge ref_clk); while (pBusy !== 1'b1);
		go <= 1'b0;
		do @(posedge ref_clk); while (pBusy !== 1'b0);
	endtask
	task t_regs;
		bus(8'h14, 1'b1, 32'hFF);
		rd(8'h14, 32'h0);
		rd(8'h00, 32'h0);
		bus(8'h00, 1'b1, 32'h1E8);
		rd(8'h00, 32'h1E8);
		rd(8'h08, 32'h0);
		$display("test regs done");
	endtask
	task t_tx(input logic [31:0] c, input logic [7:0] d, input logic [10:0] f, input logic [3:0] n);
		bus(8'h10, 1'b1, 32'hFF);
		repeat (256) @(posedge ref_clk); // reload takes hold at the next timer overflow
		bus(8'h00, 1'b1, c);
		bus(8'h04, 1'b1, {24'h0, d});
		do @(posedge ref_clk); while (txd[0] !== 1'b0);
		repeat (7) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			chk(txd[0], f[i]);
			repeat (16) @(posedge ref_clk);
		end
		rd(8'h00, c | 32'h2);
		bus(8'h00, 1'b1, c);
		rd(8'h00, c);
		$display("test tx done");
	endtask
	task t_m0tx;
		bus(8'h00, 1'b1, 32'h0);
		bus(8'h04, 1'b1, 32'h96);
		for (int i = 0; i < 8; i++) begin
			do @(posedge ref_clk); while (txd[0] !== 1'b0);
			do @(posedge ref_clk); while (txd[0] !== 1'b1);
			chk({oe[0], rxO[0]}, 32'h2 | (8'h96 >> i & 8'h1));
		end
		repeat (12) @(posedge ref_clk);
		rd(8'h00, 32'h2);
		$display("test shift done");
	endtask
	task t_m1rx;
		bus(8'h08, 1'b1, 32'h50);
		bus(8'h0C, 1'b1, 32'h5A);
		send({2'b11, 8'h3C, 1'b0}, 4'hA, 8'h10);
		rd(8'h08, 32'h57);
		send({2'b11, 8'hC3, 1'b0}, 4'hA, 8'h10);
		rd(8'h0C, 32'h3C);
		bus(8'h08, 1'b1, 32'h50);
		fork
			send({2'b11, 8'h81, 1'b0}, 4'hA, 8'h10);
			begin
				repeat (40) @(posedge ref_clk);
				rd(8'h0C, 32'h3C);
			end
		join
		rd(8'h0C, 32'h81);
		$display("test rx done");
	endtask
	task t_mp;
		bus(8'h08, 1'b1, 32'h1B0);
		send({2'b10, 8'h11, 1'b0}, 4'hB, 8'h20);
		bus(8'h08, 1'b0, 32'h0);
		chk(q & 32'h1, 32'h0);
		send({2'b01, 8'h22, 1'b0}, 4'hB, 8'h20);
		rd(8'h08, 32'h1B5);
		rd(8'h0C, 32'h22);
		$display("test multiprocessor done");
	endtask
	initial begin
		{cyc, stb, we, go, rst_b, adr, dat, frame, nBits, bitClks} = '0;
		sel = 4'hF;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_regs;
		t_tx(32'h40, 8'hA5, {2'b11, 8'hA5, 1'b0}, 4'hA);
		t_tx(32'hC0, 8'h0F, {2'b10, 8'h0F, 1'b0}, 4'hB);
		t_m0tx;
		t_m1rx;
		t_mp;
		tally_and_finish;
	end
endmodule
`default_nettype wire
